// >>> keyed_watchdog_timer.sv
// Purpose: keyed watchdog timer with AHB-Lite register access
// Assumes: single master, whole-word single transfers, one clock
// Notes: zero wait states; writes take effect at the data-phase edge

`timescale 1ns/1ns
`default_nettype none

module keyed_watchdog_timer
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Expiry actions
    output logic wdog_reset_req,
    output logic expiry_irq,
    output logic expiry_pin_n,
    // Software interrupt
    output logic irq
);
    // Configuration and state
    logic wdog_on_ff;
    logic reset_on_expiry_ff;
    logic irq_on_expiry_ff;
    logic pin_pulse_on_expiry_ff;
    logic [1:0] tick_source_sel_ff;
    logic [3:0] preload_high_nibble_ff;
    logic [15:0] count_ff;
    logic expired_flag_ff;
    logic [wdog_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [wdog_pkg::IRQ_W-1:0] irq_mask_ff;
    logic wdog_reset_req_ff;
    logic expiry_irq_ff;

    // Bus pipeline
    logic wr_pend_ff;
    logic rd_pend_ff;
    logic [7:0] addr_ff;
    logic addr_take;

    // Events
    logic tick;
    logic overflow;
    logic restart;
    logic wr_expiry_mode;
    logic wr_tick_mode;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic [wdog_pkg::IRQ_W-1:0] irq_events;

    // Register select on the word address, for the pending write data phase and the read address phase
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    // Address phase capture; always ready, always OKAY
    assign addr_take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff <= '0;
        end
        else if (hready)
        begin
            wr_pend_ff <= addr_take && hwrite;
            rd_pend_ff <= addr_take && !hwrite;
            if (addr_take)
                addr_ff <= haddr;
        end
    end

    // Write strobes: key travels in the same word as the settings; status and mask writes need no key
    assign wr_expiry_mode = wr_pend_ff && hit(addr_ff, wdog_pkg::OFS_EXPIRY_MODE)
        && hwdata[wdog_pkg::EXPIRY_KEY_LSB +: 12] == wdog_pkg::EXPIRY_CFG_KEY;
    assign wr_tick_mode = wr_pend_ff && hit(addr_ff, wdog_pkg::OFS_TICK_MODE)
        && hwdata[wdog_pkg::TICK_KEY_LSB +: 9] == wdog_pkg::TICK_CFG_KEY;
    assign restart = wr_pend_ff && hit(addr_ff, wdog_pkg::OFS_RELOAD_COMMAND)
        && hwdata[15:0] == wdog_pkg::RELOAD_KEY;
    assign wr_irq_status = wr_pend_ff && hit(addr_ff, wdog_pkg::OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_pend_ff && hit(addr_ff, wdog_pkg::OFS_IRQ_MASK);

    // Expiry mode register
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {pin_pulse_on_expiry_ff, irq_on_expiry_ff, reset_on_expiry_ff, wdog_on_ff} <=
                wdog_pkg::EXPIRY_MODE_RESET;
        end
        else if (wr_expiry_mode)
        begin
            wdog_on_ff <= hwdata[wdog_pkg::BIT_WDOG_ON];
            reset_on_expiry_ff <= hwdata[wdog_pkg::BIT_RESET_ON_EXPIRY];
            irq_on_expiry_ff <= hwdata[wdog_pkg::BIT_IRQ_ON_EXPIRY];
            pin_pulse_on_expiry_ff <= hwdata[wdog_pkg::BIT_PIN_PULSE_ON_EXPIRY];
        end
    end

    // Tick mode register
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            {preload_high_nibble_ff, tick_source_sel_ff} <= wdog_pkg::TICK_MODE_RESET;
        else if (wr_tick_mode)
        begin
            tick_source_sel_ff <= hwdata[wdog_pkg::TICK_SEL_LSB +: 2];
            preload_high_nibble_ff <= hwdata[wdog_pkg::PRELOAD_LSB +: 4];
        end
    end

    // Tick source; the prescaler only runs while enabled
    wdog_tick_gen u_tick
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(wdog_on_ff),
        .sel(tick_source_sel_ff),
        .tick(tick)
    );

    // Overflow is a tick seen at zero
    assign overflow = tick && wdog_on_ff && count_ff == '0 && !restart;

    // Down counter; restart wins over a tick in the same cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            count_ff <= wdog_pkg::COUNT_RESET;
        else if (restart)
            count_ff <= {preload_high_nibble_ff, wdog_pkg::PRELOAD_LOW};
        else if (tick && wdog_on_ff)
            count_ff <= count_ff - 1'b1;
    end

    // Expired flag; held until restart clears it
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            expired_flag_ff <= 1'b0;
        else if (overflow)
            expired_flag_ff <= 1'b1;
        else if (restart)
            expired_flag_ff <= 1'b0;
    end

    // One-cycle action pulses, gated by the enable bit
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wdog_reset_req_ff <= 1'b0;
            expiry_irq_ff <= 1'b0;
        end
        else
        begin
            wdog_reset_req_ff <= overflow && reset_on_expiry_ff;
            expiry_irq_ff <= overflow && irq_on_expiry_ff;
        end
    end

    assign wdog_reset_req = wdog_reset_req_ff;
    assign expiry_irq = expiry_irq_ff;

    // Active-low expiry pin
    wdog_pin_pulse #(.LEN(wdog_pkg::PIN_LOW_CYCLES)) u_pin
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .fire(overflow && pin_pulse_on_expiry_ff),
        .pin_n(expiry_pin_n)
    );

    // Sticky interrupt status; a new event wins over write-one-to-clear
    assign irq_events[wdog_pkg::IRQ_BIT_EXPIRY] = overflow;
    assign irq_events[wdog_pkg::IRQ_BIT_RESTART] = restart;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_stat_ff <= '0;
        else
            irq_stat_ff <= (irq_stat_ff & ~(wr_irq_status ? hwdata[wdog_pkg::IRQ_W-1:0] : '0)) | irq_events;
    end

    // Interrupt mask
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_mask_ff <= '0;
        else if (wr_irq_mask)
            irq_mask_ff <= hwdata[wdog_pkg::IRQ_W-1:0];
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Read data registered at the address phase; keys always read zero
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            hrdata <= '0;
        else if (addr_take && !hwrite)
        begin
            hrdata <= '0;
            if (hit(haddr, wdog_pkg::OFS_EXPIRY_MODE))
                hrdata[3:0] <= {pin_pulse_on_expiry_ff, irq_on_expiry_ff,
                    reset_on_expiry_ff, wdog_on_ff};
            else if (hit(haddr, wdog_pkg::OFS_TICK_MODE))
                hrdata[5:0] <= {preload_high_nibble_ff, tick_source_sel_ff};
            else if (hit(haddr, wdog_pkg::OFS_EXPIRY_STATUS))
                hrdata[0] <= expired_flag_ff;
            else if (hit(haddr, wdog_pkg::OFS_IRQ_STATUS))
                hrdata[wdog_pkg::IRQ_W-1:0] <= irq_stat_ff;
            else if (hit(haddr, wdog_pkg::OFS_IRQ_MASK))
                hrdata[wdog_pkg::IRQ_W-1:0] <= irq_mask_ff;
        end
    end
endmodule // keyed_watchdog_timer

`default_nettype wire

// >>> keyed_watchdog_timer_tb.sv
// Purpose: register and expiry tests for the watchdog
// Assumes: zero wait state slave, fastest tick for the long run
// Notes: one full timeout of 4096 ticks of 8 cycles
`timescale 1ns/1ns
`default_nettype none
module keyed_watchdog_timer_tb;
    logic core_clk, arst_n, hwrite, hreadyout, hresp, rreq, eirq, pin_n, irq;
    logic [1:0] htrans;
    logic [7:0] haddr;
    logic [31:0] hwdata, hrdata, v, rst_cnt, irq_cnt, low_len;
    int num_errors = 0;
    int checks = 0;
    int n;
    keyed_watchdog_timer keyed_watchdog_timer_i (.core_clk(core_clk), .arst_n(arst_n), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wdog_reset_req(rreq), .expiry_irq(eirq),
        .expiry_pin_n(pin_n), .irq(irq));
    wdog_partner wdog_partner_i (.core_clk(core_clk), .arst_n(arst_n), .wdog_reset_req(rreq),
        .expiry_irq(eirq), .expiry_pin_n(pin_n), .rst_cnt(rst_cnt), .irq_cnt(irq_cnt), .low_len(low_len));
    always #5 core_clk = ~core_clk;
    // Bus cycle: address phase, then data phase, each held until ready
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        v = hrdata;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task report_and_stop;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog on the run itself; the timeout needs about 33k cycles
    initial
    begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        report_and_stop;
    end
    initial
    begin
        core_clk = 0;
        arst_n = 0;
        haddr = 0;
        htrans = 0;
        hwrite = 0;
        hwdata = 0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        // Reset values, skipping the write-only slot; 0x18 is unmapped
        for (int i = 0; i < 7; i++)
            if (i != 2) rc(8'(i * 4), 32'h0000_0000);
        // Wrong keys change nothing
        bus(1'b1, 8'h00, 32'h0000_235f);
        rc(8'h00, 32'h0000_0000);
        bus(1'b1, 8'h04, 32'h0000_37bc);
        rc(8'h04, 32'h0000_0000);
        // Keyed writes land, key field reads back zero
        bus(1'b1, 8'h00, 32'h0000_234e);
        rc(8'h00, 32'h0000_000e);
        bus(1'b1, 8'h00, 32'h0000_2340);
        rc(8'h00, 32'h0000_0000);
        bus(1'b1, 8'h04, 32'h0000_373c);
        rc(8'h04, 32'h0000_003c);
        bus(1'b1, 8'h04, 32'h0000_3700);
        rc(8'h04, 32'h0000_0000);
        // Reload key seen through the restart event bit
        bus(1'b1, 8'h14, 32'h0000_0001);
        bus(1'b1, 8'h08, 32'h0000_c070);
        rc(8'h10, 32'h0000_0000);
        bus(1'b1, 8'h08, 32'h0000_c071);
        rc(8'h10, 32'h0000_0002);
        bus(1'b1, 8'h10, 32'h0000_0002);
        rc(8'h10, 32'h0000_0000);
        chk("irq", 32'h0000_0000, 32'(irq));
        // All actions on; preload 0xFFF at MASTER_CLOCK/8 gives 4096 ticks
        bus(1'b1, 8'h00, 32'h0000_234f);
        n = 0;
        while (eirq !== 1'b1 && n < 40000)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("expiry time", 32'h0000_0001, 32'(n >= 32760 && n <= 32776));
        repeat (12) @(posedge core_clk);
        chk("reset pulses", 32'h0000_0001, rst_cnt);
        chk("irq pulses", 32'h0000_0001, irq_cnt);
        chk("pin low", 32'h0000_0008, low_len);
        chk("irq", 32'h0000_0001, 32'(irq));
        rc(8'h0c, 32'h0000_0001);
        bus(1'b1, 8'h0c, 32'h0000_0000);
        rc(8'h0c, 32'h0000_0001);
        // Mask then clear the sticky bit
        bus(1'b1, 8'h14, 32'h0000_0000);
        @(posedge core_clk);
        chk("irq masked", 32'h0000_0000, 32'(irq));
        bus(1'b1, 8'h10, 32'h0000_0001);
        rc(8'h10, 32'h0000_0000);
        bus(1'b1, 8'h08, 32'h0000_c071);
        rc(8'h0c, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_2340);
        report_and_stop;
    end
endmodule // keyed_watchdog_timer_tb
`default_nettype wire

// >>> wdog_chk.sv
// Purpose: concurrent checks on the watchdog ports
// Assumes: one clock, bound to the top module
// Notes: shadows keyed mode writes to know the enables
`timescale 1ns/1ns
`default_nettype none
module wdog_chk
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Bus
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Expiry actions
    input wire logic wdog_reset_req,
    input wire logic expiry_irq,
    input wire logic expiry_pin_n
);
    logic ph_ff;
    logic wr_ff;
    logic [7:0] ad_ff;
    logic [3:0] mode_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Data phase and mode shadow; a rejected key leaves the shadow alone
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ph_ff <= 1'b0;
            wr_ff <= 1'b0;
            ad_ff <= 8'h00;
            mode_ff <= 4'h0;
        end
        else
        begin
            ph_ff <= hsel && hready && htrans[1];
            wr_ff <= hwrite;
            ad_ff <= haddr;
            if (ph_ff && wr_ff && ad_ff == 8'h00 && hwdata[15:4] == 12'h234)
                mode_ff <= hwdata[3:0];
        end
    end
    a_irq_one_cycle:
        assert property (expiry_irq |=> !expiry_irq) else $error("expiry irq wider than one cycle");
    a_req_one_cycle:
        assert property (wdog_reset_req |=> !wdog_reset_req) else $error("reset request too wide");
    a_pin_eight_low:
        assert property ($fell(expiry_pin_n) |-> !expiry_pin_n [*8] ##1 expiry_pin_n)
        else $error("expiry pin low time wrong");
    a_off_is_quiet:
        assert property (!mode_ff[0] && !$past(mode_ff[0]) |-> !expiry_irq && !wdog_reset_req)
        else $error("action while disabled");
    a_req_with_irq:
        assert property (expiry_irq && $past(mode_ff[1]) |-> wdog_reset_req) else $error("reset request missing");
    a_irq_with_req:
        assert property (wdog_reset_req && $past(mode_ff[2]) |-> expiry_irq) else $error("expiry irq missing");
    a_pin_with_irq:
        assert property (expiry_irq && $past(mode_ff[3]) |-> !expiry_pin_n) else $error("expiry pin not driven");
    a_bus_okay:
        assert property (hreadyout && !hresp) else $error("bus response not ready okay");
    a_exp_key_zero:
        assert property (ph_ff && !wr_ff && ad_ff == 8'h00 |-> hrdata[15:4] == 12'h000)
        else $error("expiry key reads nonzero");
    a_tick_key_zero:
        assert property (ph_ff && !wr_ff && ad_ff == 8'h04 |-> hrdata[15:7] == 9'h000)
        else $error("tick key reads nonzero");
endmodule // wdog_chk
bind keyed_watchdog_timer wdog_chk wdog_chk_i (.core_clk(core_clk), .arst_n(arst_n), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsel(hsel), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wdog_reset_req(wdog_reset_req), .expiry_irq(expiry_irq),
    .expiry_pin_n(expiry_pin_n));
`default_nettype wire

// >>> wdog_partner.sv
// Purpose: reset logic, interrupt controller and supervisor stand-in
// Assumes: one clock
// Notes: only counts what it sees; never drives the block
`timescale 1ns/1ns
`default_nettype none
module wdog_partner
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Expiry actions
    input wire logic wdog_reset_req,
    input wire logic expiry_irq,
    input wire logic expiry_pin_n,
    // Observations
    output logic [31:0] rst_cnt,
    output logic [31:0] irq_cnt,
    output logic [31:0] low_len
);
    logic [31:0] run_ff;
    // Pulse counts and length of the last low run of the pin
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_cnt <= '0;
            irq_cnt <= '0;
            low_len <= '0;
            run_ff <= '0;
        end
        else
        begin
            rst_cnt <= rst_cnt + 32'(wdog_reset_req);
            irq_cnt <= irq_cnt + 32'(expiry_irq);
            run_ff <= expiry_pin_n ? 32'h0000_0000 : run_ff + 1;
            if (expiry_pin_n && run_ff != 0)
                low_len <= run_ff;
        end
    end
endmodule // wdog_partner
`default_nettype wire

// >>> wdog_pin_pulse.sv
// Purpose: fixed-length active-low pulse on the expiry pin
// Assumes: master clock only
// Notes: a new trigger during a pulse restarts the full length

`timescale 1ns/1ns
`default_nettype none

module wdog_pin_pulse
#(
    parameter int LEN = wdog_pkg::PIN_LOW_CYCLES
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Trigger
    input wire logic fire,
    // Pin
    output logic pin_n
);
    logic [3:0] left_ff;

    // Count down the low time
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            left_ff <= '0;
        else if (fire)
            left_ff <= 4'(LEN);
        else if (left_ff != '0)
            left_ff <= left_ff - 1'b1;
    end

    // Registered so the pin never glitches
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            pin_n <= 1'b1;
        else
            pin_n <= !(fire || left_ff > 4'd1);
    end
endmodule // wdog_pin_pulse

`default_nettype wire

// >>> wdog_pkg.sv
// Purpose: shared constants for the keyed watchdog timer
// Assumes: 32-bit register bus, one master clock domain
// Notes: offsets are byte addresses; dividers and pin low time in master clock cycles, counter values in ticks

`default_nettype none

package wdog_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_EXPIRY_MODE = 8'h00;
    localparam logic [7:0] OFS_TICK_MODE = 8'h04;
    localparam logic [7:0] OFS_RELOAD_COMMAND = 8'h08;
    localparam logic [7:0] OFS_EXPIRY_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // Expiry mode fields
    localparam int BIT_WDOG_ON = 0;
    localparam int BIT_RESET_ON_EXPIRY = 1;
    localparam int BIT_IRQ_ON_EXPIRY = 2;
    localparam int BIT_PIN_PULSE_ON_EXPIRY = 3;
    localparam int EXPIRY_KEY_LSB = 4;
    localparam logic [11:0] EXPIRY_CFG_KEY = 12'h234;

    // Tick mode fields
    localparam int TICK_SEL_LSB = 0;
    localparam int PRELOAD_LSB = 2;
    localparam int TICK_KEY_LSB = 7;
    localparam logic [8:0] TICK_CFG_KEY = 9'h06e;

    // Reload command key
    localparam logic [15:0] RELOAD_KEY = 16'hc071;

    // Counter and reset values
    localparam logic [11:0] PRELOAD_LOW = 12'hfff;
    localparam logic [3:0] EXPIRY_MODE_RESET = 4'h0;
    localparam logic [5:0] TICK_MODE_RESET = 6'h00;
    localparam logic [15:0] COUNT_RESET = 16'hffff;

    // Tick dividers in master clock cycles
    localparam int DIV_SEL0 = 8;
    localparam int DIV_SEL1 = 32;
    localparam int DIV_SEL2 = 128;
    localparam int DIV_SEL3 = 1024;
    localparam int PRESCALE_W = 10;

    // Expiry pin low time
    localparam int PIN_LOW_CYCLES = 8;

    // Interrupt status bits (one per event)
    localparam int IRQ_BIT_EXPIRY = 0;
    localparam int IRQ_BIT_RESTART = 1;
    localparam int IRQ_W = 2;
endpackage

`default_nettype wire

// >>> wdog_tick_gen.sv
// Purpose: selectable tick enable for the watchdog counter
// Assumes: master clock only
// Notes: prescaler runs only while enabled, pulse on every Nth cycle

`timescale 1ns/1ns
`default_nettype none

module wdog_tick_gen
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Control
    input wire logic run,
    input wire logic [1:0] sel,
    // Tick out
    output logic tick
);
    logic [wdog_pkg::PRESCALE_W-1:0] presc_ff;
    logic [wdog_pkg::PRESCALE_W-1:0] last;

    // Terminal count for the selected division
    always_comb
    begin
        unique case (sel)
            2'b00: last = (wdog_pkg::PRESCALE_W)'(wdog_pkg::DIV_SEL0 - 1);
            2'b01: last = (wdog_pkg::PRESCALE_W)'(wdog_pkg::DIV_SEL1 - 1);
            2'b10: last = (wdog_pkg::PRESCALE_W)'(wdog_pkg::DIV_SEL2 - 1);
            2'b11: last = (wdog_pkg::PRESCALE_W)'(wdog_pkg::DIV_SEL3 - 1);
        endcase
    end

    // Held at zero while stopped so the first tick is a full period
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            presc_ff <= '0;
        else if (!run || presc_ff >= last)
            presc_ff <= '0;
        else
            presc_ff <= presc_ff + 1'b1;
    end

    assign tick = run && (presc_ff >= last);
endmodule // wdog_tick_gen

`default_nettype wire
